// [verilog/swlcs_pkg.sv]
// Package with register map, field layout and carrier types of the link control block.
package swlcs_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_RSVD_A = 10'h010;
    localparam logic [9:0] IDX_RSVD_B = 10'h011;
    localparam logic [9:0] IDX_DBG    = 10'h01f;
    localparam logic [9:0] IDX_EXT    = 10'h020;
    localparam logic [9:0] IDX_PROC   = 10'h040;
    localparam logic [9:0] IDX_CFG    = 10'h080;
    localparam logic [9:0] IDX_STAT   = 10'h0a0;
    localparam int NUM_LINKS = 8;

    // Field positions.
    localparam int DBG_ZERO_BIT  = 0;
    localparam int DBG_ONE_BIT   = 1;
    localparam int DBG_RSVD_BIT  = 4;
    localparam int ST_TYPE_LO    = 24;
    localparam int ST_DEST_LO    = 16;
    localparam int ST_DIR_LO     = 8;
    localparam int ST_NET_LO     = 4;
    localparam int ST_JUNK_BIT   = 2;
    localparam int ST_DUSE_BIT   = 1;
    localparam int ST_SUSE_BIT   = 0;
    localparam int CF_EN_BIT     = 31;
    localparam int CF_WIDE_BIT   = 30;
    localparam int CF_ERR_BIT    = 27;
    localparam int CF_ISSUED_BIT = 26;
    localparam int CF_HELD_BIT   = 25;
    localparam int CF_CREDIT_REQUEST_TOKEN_BIT  = 24;
    localparam int CF_RXRST_BIT  = 23;
    localparam int CF_SYM_LO     = 11;
    localparam int CF_TOK_LO     = 0;
    localparam int SL_EN_BIT     = 31;
    localparam int SL_CH_LO      = 0;

    // Reset values.
    localparam logic [1:0]  RST_RSVD = 2'h0;
    localparam logic [1:0]  RST_DBG  = 2'h0;
    localparam logic [3:0]  RST_DIR  = 4'h0;
    localparam logic [1:0]  RST_NET  = 2'h0;
    localparam logic [10:0] RST_GAP  = 11'h000;
    localparam logic [4:0]  RST_CH   = 5'h00;

    // Static register slot to link letter (A=0 .. H=7): C, D, A, B, G, H, E, F.
    localparam logic [2:0] STAT_LINK [8] = '{3'h2, 3'h3, 3'h0, 3'h1,
                                              3'h6, 3'h7, 3'h4, 3'h5};

    typedef enum logic [1:0] {
        SRC_SWITCH_LINK  = 2'h0,
        SRC_PROC_LINK    = 2'h1,
        SRC_CTRL_TARGET  = 2'h2,
        SRC_UNDEFINED    = 2'h3
    } swlcs_src_type;

    // Live state of one link as reported by the switch fabric.
    typedef struct packed {
        swlcs_src_type sourceTargetType;
        logic [7:0]    destLink;
        logic          junk;
        logic          destInUse;
        logic          srcInUse;
    } swlcs_link_stat_type;

    // Settings driven to one external link.
    typedef struct packed {
        logic        enable;
        logic        fiveWire;
        logic [3:0]  direction;
        logic [1:0]  network;
        logic [10:0] symbolGap;
        logic [10:0] tokenGap;
    } swlcs_link_cfg_type;

    // Events and levels reported by one external link.
    typedef struct packed {
        logic rxError;
        logic creditIssued;
        logic creditHeld;
        logic rxSpace;
    } swlcs_link_evt_type;
endpackage

// [verilog/swlcs_top.sv]
// Link control and status registers of the packet switch, with an APB slave.
//Contract
// R01: Debug source bit 0 marks core zero, bit 1 core one as last event raiser.
// R02: Status bits 25:24 give source target kind: switch, processor, control, undefined.
// R03: Status bits 23:16 hold destination link number while the link is used.
// R04: External status bits 11:8 are a writable direction field, reset zero.
// R05: Every link has writable network field 5:4, reset zero.
// R06: Status bit 2 reads one while the current packet is junk.
// R07: Status bit 1 shows destination side busy, bit 0 source side busy.
// R08: Processor link registers start at 0x40, no direction field.
// R09: Config bit 31 enables the external link and selects pin muxing.
// R10: Config bit 30 picks 2-wire at zero (reset) or 5-wire at one.
// R11: Read-only config bit 27 sets on receive overflow or illegal token.
// R12: Read-only bit 26 shows this end has issued credit to remote.
// R13: Read-only bit 25 shows this end holds credit to transmit.
// R14: Writing one to bit 24 clears own credit and sends credit request.
// R15: Writing one to bit 23 resets receiver to await a token start.
// R16: Field 21:11 sets idle clocks between symbols, count minus one.
// R17: Field 10:0 sets idle clocks between tokens, count minus one.
// R18: Static bit 31 forwards all link traffic to one channel end.
// R19: Static field 4:0 selects the receiving local channel end.
// R20: Static registers from 0xA0 map to links C, D, A, B, G, H, E, F.
// R21: Reserved registers hold two writable low bits, reset zero.
// R22: Routed packets leave by direction of highest bit differing from node id.
// R23: No end transmits without credit; credit granted only with buffer space.
//
// Local design decision: the APB register port.
module swlcs_top
    import swlcs_pkg::*;
(
    // Clock and reset.
    input  wire logic                                mclk,
    input  wire logic                                rst,
    // APB slave.
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [11:0]                         paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // Debug events, one-cycle pulses.
    input  wire logic                                coreZeroDebug,
    input  wire logic                                coreOneDebug,
    // Fabric status.
    input  wire swlcs_link_stat_type [NUM_LINKS-1:0] extStat,
    input  wire swlcs_link_stat_type [NUM_LINKS-1:0] procStat,
    // External link side.
    input  wire swlcs_link_evt_type  [NUM_LINKS-1:0] linkEvt,
    output swlcs_link_cfg_type       [NUM_LINKS-1:0] linkCfg,
    output logic      [NUM_LINKS-1:0]                creditRequest,
    output logic      [NUM_LINKS-1:0]                rxReset,
    output logic      [NUM_LINKS-1:0]                txPermit,
    output logic      [NUM_LINKS-1:0]                creditGrantOk,
    // Processor links and static forwarding, indexed by link letter A..H.
    output logic      [NUM_LINKS-1:0][1:0]           procNetwork,
    output logic      [NUM_LINKS-1:0]                staticEnable,
    output logic      [NUM_LINKS-1:0][4:0]           staticChanEnd,
    // Routing lookup.
    input  wire logic                                routeValid,
    input  wire logic [15:0]                         routeDest,
    input  wire logic [15:0]                         nodeId,
    input  wire logic [15:0][3:0]                    dirTable,
    output logic                                     routeDone,
    output logic      [3:0]                          routeDir,
    output logic                                     routeLocal
);
    // Bus decode.
    logic [9:0]  idx;
    logic [2:0]  sub;
    logic        accessPh;
    logic        hitRsvdA;
    logic        hitRsvdB;
    logic        hitDbg;
    logic        hitExt;
    logic        hitProc;
    logic        hitCfg;
    logic        hitStat;
    logic        mapped;
    logic        wrEn;
    logic [31:0] rdData;

    assign idx      = paddr[11:2];
    assign sub      = paddr[4:2];
    assign accessPh = psel & penable & ~pready;
    assign hitRsvdA = idx == IDX_RSVD_A;
    assign hitRsvdB = idx == IDX_RSVD_B;
    assign hitDbg   = idx == IDX_DBG;
    assign hitExt   = idx[9:3] == IDX_EXT[9:3];
    assign hitProc  = idx[9:3] == IDX_PROC[9:3];
    assign hitCfg   = idx[9:3] == IDX_CFG[9:3];
    assign hitStat  = idx[9:3] == IDX_STAT[9:3];
    assign mapped   = hitRsvdA | hitRsvdB | hitDbg | hitExt | hitProc | hitCfg | hitStat;
    assign wrEn     = accessPh & pwrite & mapped;

    // Register storage.
    logic [1:0] rsvdA_r;
    logic [1:0] rsvdB_r;
    logic [1:0] dbgSrc_r;
    logic       dbgRsvd_r;
    logic [NUM_LINKS-1:0] cfgErr_r;

    // Software-side reserved bits.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsvdA_r <= RST_RSVD; // R21
            rsvdB_r <= RST_RSVD;
        end else begin
            if (wrEn & hitRsvdA)
                rsvdA_r <= pwdata[1:0]; // R21
            if (wrEn & hitRsvdB)
                rsvdB_r <= pwdata[1:0];
        end
    end

    // A debug event outranks a software write in the same cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbgSrc_r  <= RST_DBG;
            dbgRsvd_r <= 1'b0;
        end else begin
            if (coreZeroDebug | coreOneDebug)
                dbgSrc_r <= {coreOneDebug, coreZeroDebug}; // R01
            else if (wrEn & hitDbg)
                dbgSrc_r <= {pwdata[DBG_ONE_BIT], pwdata[DBG_ZERO_BIT]};
            if (wrEn & hitDbg)
                dbgRsvd_r <= pwdata[DBG_RSVD_BIT];
        end
    end

    // Per-link registers.
    genvar g;
    generate
        for (g = 0; g < NUM_LINKS; g++) begin : gLink
            logic wrExt;
            logic wrProc;
            logic wrCfg;
            logic wrStat;
            logic linkHeld;
            assign wrExt    = wrEn & hitExt  & (sub == 3'(g));
            assign wrProc   = wrEn & hitProc & (sub == 3'(g));
            assign wrCfg    = wrEn & hitCfg  & (sub == 3'(g));
            assign wrStat   = wrEn & hitStat & (sub == 3'(g));
            assign linkHeld = linkEvt[g].creditHeld & ~creditRequest[g];

            always_ff @(posedge mclk) begin
                if (rst) begin
                    linkCfg[g].enable    <= 1'b0;
                    linkCfg[g].fiveWire  <= 1'b0;
                    linkCfg[g].direction <= RST_DIR;
                    linkCfg[g].network   <= RST_NET;
                    linkCfg[g].symbolGap <= RST_GAP;
                    linkCfg[g].tokenGap  <= RST_GAP;
                    procNetwork[g]       <= RST_NET;
                    cfgErr_r[g]          <= 1'b0;
                    creditRequest[g]     <= 1'b0;
                    rxReset[g]           <= 1'b0;
                    txPermit[g]          <= 1'b0;
                    creditGrantOk[g]     <= 1'b0;
                end else begin
                    if (wrExt) begin
                        linkCfg[g].direction <= pwdata[ST_DIR_LO+:4]; // R04
                        linkCfg[g].network   <= pwdata[ST_NET_LO+:2]; // R05
                    end
                    if (wrProc)
                        procNetwork[g] <= pwdata[ST_NET_LO+:2]; // R05 R08
                    if (wrCfg) begin
                        linkCfg[g].enable    <= pwdata[CF_EN_BIT]; // R09
                        linkCfg[g].fiveWire  <= pwdata[CF_WIDE_BIT]; // R10
                        linkCfg[g].symbolGap <= pwdata[CF_SYM_LO+:11]; // R16
                        linkCfg[g].tokenGap  <= pwdata[CF_TOK_LO+:11]; // R17
                    end
                    // A new error wins over the clear by receiver reset.
                    if (linkEvt[g].rxError)
                        cfgErr_r[g] <= 1'b1; // R11
                    else if (wrCfg & pwdata[CF_RXRST_BIT])
                        cfgErr_r[g] <= 1'b0;
                    creditRequest[g] <= wrCfg & pwdata[CF_CREDIT_REQUEST_TOKEN_BIT]; // R14
                    rxReset[g]       <= wrCfg & pwdata[CF_RXRST_BIT]; // R15
                    // Transmit is withheld the cycle a credit request is issued.
                    txPermit[g] <= linkCfg[g].enable & linkHeld
                                   & ~(wrCfg & pwdata[CF_CREDIT_REQUEST_TOKEN_BIT]); // R23
                    creditGrantOk[g] <= linkCfg[g].enable & linkEvt[g].rxSpace; // R23
                end
            end

            // Static slot g drives the link named by the slot table; the index is
            // a constant, so each element keeps exactly one driver.
            always_ff @(posedge mclk) begin
                if (rst) begin
                    staticEnable[STAT_LINK[g]]  <= 1'b0;
                    staticChanEnd[STAT_LINK[g]] <= RST_CH;
                end else if (wrStat) begin
                    staticEnable[STAT_LINK[g]]  <= pwdata[SL_EN_BIT]; // R18 R20
                    staticChanEnd[STAT_LINK[g]] <= pwdata[SL_CH_LO+:5]; // R19
                end
            end
        end
    endgenerate

    // Status words share one layout for external and processor links.
    function automatic logic [31:0] statWord(input swlcs_link_stat_type s,
                                             input logic [3:0] dir,
                                             input logic [1:0] net);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ST_TYPE_LO+:2] = s.sourceTargetType; // R02
        w[ST_DEST_LO+:8] = s.srcInUse ? s.destLink : 8'h00; // R03
        w[ST_DIR_LO+:4]  = dir;
        w[ST_NET_LO+:2]  = net;
        w[ST_JUNK_BIT]   = s.junk; // R06
        w[ST_DUSE_BIT]   = s.destInUse; // R07
        w[ST_SUSE_BIT]   = s.srcInUse;
        return w;
    endfunction

    function automatic logic [31:0] cfgWord(input swlcs_link_cfg_type c,
                                            input swlcs_link_evt_type e,
                                            input logic err);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CF_EN_BIT]       = c.enable;
        w[CF_WIDE_BIT]     = c.fiveWire;
        w[CF_ERR_BIT]      = err;
        w[CF_ISSUED_BIT]   = e.creditIssued; // R12
        w[CF_HELD_BIT]     = e.creditHeld; // R13
        w[CF_SYM_LO+:11]   = c.symbolGap;
        w[CF_TOK_LO+:11]   = c.tokenGap;
        return w;
    endfunction

    logic [2:0] statLink;
    assign statLink = STAT_LINK[sub];

    always_comb begin
        rdData = 32'h0000_0000;
        if (hitRsvdA)
            rdData[1:0] = rsvdA_r;
        else if (hitRsvdB)
            rdData[1:0] = rsvdB_r;
        else if (hitDbg) begin
            rdData[DBG_ONE_BIT:DBG_ZERO_BIT] = dbgSrc_r;
            rdData[DBG_RSVD_BIT] = dbgRsvd_r;
        end else if (hitExt)
            rdData = statWord(extStat[sub], linkCfg[sub].direction, linkCfg[sub].network);
        else if (hitProc)
            rdData = statWord(procStat[sub], RST_DIR, procNetwork[sub]); // R08
        else if (hitCfg)
            rdData = cfgWord(linkCfg[sub], linkEvt[sub], cfgErr_r[sub]);
        else if (hitStat) begin
            rdData[SL_EN_BIT] = staticEnable[statLink];
            rdData[SL_CH_LO+:5] = staticChanEnd[statLink];
        end
    end

    // One wait state: pready rises in the first access cycle's following edge.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= accessPh;
            pslverr <= accessPh & ~mapped;
            if (accessPh & ~pwrite)
                prdata <= rdData;
        end
    end

    // Routing: highest differing bit of destination and node id picks the direction.
    logic [3:0]  msbDiff;
    logic [15:0] diff;
    assign diff = routeDest ^ nodeId;

    always_comb begin
        msbDiff = 4'h0;
        for (int i = 0; i < 16; i++)
            if (diff[i])
                msbDiff = 4'(i);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            routeDone  <= 1'b0;
            routeDir   <= RST_DIR;
            routeLocal <= 1'b0;
        end else begin
            routeDone <= routeValid;
            if (routeValid) begin
                routeDir   <= dirTable[msbDiff]; // R22
                routeLocal <= diff == 16'h0000;
            end
        end
    end
endmodule

// [dv/swlcs_checker_assertions.sv]
// Concurrent checks on the bus, link two and routing ports of the link control block.
module swlcs_checker
    import swlcs_pkg::*;
(
    // Clock, reset and bus.
    input wire logic                               mclk,
    input wire logic                               rst,
    input wire logic                               psel,
    input wire logic                               penable,
    input wire logic                               pwrite,
    input wire logic [11:0]                        paddr,
    input wire logic [31:0]                        pwdata,
    input wire logic                               pready,
    input wire logic                               pslverr,
    // Link side.
    input wire swlcs_link_evt_type [NUM_LINKS-1:0] linkEvt,
    input wire swlcs_link_cfg_type [NUM_LINKS-1:0] linkCfg,
    input wire logic [NUM_LINKS-1:0]               creditRequest,
    input wire logic [NUM_LINKS-1:0]               rxReset,
    input wire logic [NUM_LINKS-1:0]               txPermit,
    input wire logic [NUM_LINKS-1:0]               creditGrantOk,
    // Routing.
    input wire logic                               routeValid,
    input wire logic [15:0]                        routeDest,
    input wire logic [15:0]                        nodeId,
    input wire logic [15:0][3:0]                   dirTable,
    input wire logic                               routeDone,
    input wire logic [3:0]                         routeDir,
    input wire logic                               routeLocal
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire take  = psel && penable && !pready;
    wire cfgWr = take && pwrite && paddr[11:2] == IDX_CFG + 10'h2;

    a_cfg_write_lands: assert property (cfgWr |=> linkCfg[2].tokenGap == $past(pwdata[10:0])
        && linkCfg[2].enable == $past(pwdata[31])) else $error("config write not applied");
    a_credit_req_pulse: assert property (cfgWr && pwdata[24] |-> ##[1:2] creditRequest[2])
        else $error("credit request pulse missing");
    a_rx_reset_pulse: assert property (cfgWr && pwdata[23] |-> ##[1:2] rxReset[2])
        else $error("receiver reset pulse missing");
    a_permit_needs_credit: assert property (txPermit[2] |-> $past(linkEvt[2].creditHeld)
        && $past(linkCfg[2].enable)) else $error("transmit allowed without credit");
    a_grant_needs_space: assert property (creditGrantOk[2] |-> $past(linkEvt[2].rxSpace))
        else $error("credit granted without space");
    a_route_answer: assert property (routeValid |=> routeDone)
        else $error("route lookup not answered");
    a_route_local: assert property (routeValid && routeDest == nodeId |=> routeLocal)
        else $error("local destination not flagged");
    a_route_top_dir: assert property (routeValid && (routeDest[15] ^ nodeId[15])
        |=> routeDir == $past(dirTable[15])) else $error("wrong route direction");
    a_unmapped_err: assert property (take && paddr[11:2] == 10'h028 |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
endmodule

bind swlcs_top swlcs_checker swlcs_checker_i (.*);

// [dv/swlcs_peer_model.sv]
// Behavioural far end of the external links: credit, receive space and bad tokens.
module swlcs_peer_model
    import swlcs_pkg::*;
(
    // Clock and reset.
    input  wire logic                               mclk,
    input  wire logic                               rst,
    // Block side.
    input  wire swlcs_link_cfg_type [NUM_LINKS-1:0] linkCfg,
    input  wire logic [NUM_LINKS-1:0]               creditRequest,
    input  wire logic [NUM_LINKS-1:0]               creditGrantOk,
    output swlcs_link_evt_type [NUM_LINKS-1:0]      linkEvt,
    // Bench controls: answer delay, full buffer, corrupt token.
    input  wire logic [7:0]                         grantDelay,
    input  wire logic [NUM_LINKS-1:0]               rxFull,
    input  wire logic [NUM_LINKS-1:0]               badToken
);
    logic [NUM_LINKS-1:0][7:0] waitCnt_r;

    // Credit is only regranted after a delay, so a request is seen to drop it first.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NUM_LINKS; i++) begin
            linkEvt[i].rxError <= badToken[i] && !rst;
            linkEvt[i].rxSpace <= linkCfg[i].enable && !rxFull[i] && !rst;
            linkEvt[i].creditIssued <= creditGrantOk[i] && !rxFull[i] && !rst;
            if (rst || !linkCfg[i].enable || creditRequest[i]) begin
                linkEvt[i].creditHeld <= 1'b0;
                waitCnt_r[i] <= 8'h00;
            end else if (waitCnt_r[i] >= grantDelay) begin
                linkEvt[i].creditHeld <= 1'b1;
            end else begin
                waitCnt_r[i] <= waitCnt_r[i] + 8'h01;
            end
        end
    end
endmodule

// [dv/test_swlcs_top.sv]
// Self-checking bench for the link control and status registers.
module test_swlcs_top
    import swlcs_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic                                mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic                                errq;
    logic                                coreZeroDebug, coreOneDebug;
    logic                                routeValid, routeDone, routeLocal;
    logic [11:0]                         paddr;
    logic [31:0]                         pwdata, prdata, rdq, w, cfgW;
    logic [15:0]                         routeDest, nodeId;
    logic [15:0][3:0]                    dirTable;
    logic [3:0]                          routeDir;
    logic [7:0]                          grantDelay;
    swlcs_link_stat_type [NUM_LINKS-1:0] extStat, procStat;
    swlcs_link_evt_type [NUM_LINKS-1:0]  linkEvt;
    swlcs_link_cfg_type [NUM_LINKS-1:0]  linkCfg;
    logic [NUM_LINKS-1:0]                creditRequest, rxReset, txPermit, creditGrantOk;
    logic [NUM_LINKS-1:0]                staticEnable, rxFull, badToken;
    logic [NUM_LINKS-1:0][1:0]           procNetwork;
    logic [NUM_LINKS-1:0][4:0]           staticChanEnd;
    int                                  num_errors = 0, num_checks = 0;

    swlcs_top swlcs_top_i (.*);
    swlcs_peer_model swlcs_peer_model_i (.*);

    always #5 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Called just after a rising edge; returns one edge after the access ended.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            tally_and_finish();
        end
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [9:0] idx, input string nm, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(nm, exp, rdq);
    endtask

    task automatic poll_credit();
        int n;
        n = 0;
        do begin
            apb(1'b0, IDX_CFG + 10'h2, 32'h0);
            n++;
        end while (rdq[CF_HELD_BIT] !== 1'b1 && n < 20);
        chk("credit held", 32'h1, 32'(rdq[CF_HELD_BIT]));
        chk("tx permit", 32'h1, 32'(txPermit[2]));
    endtask

    task automatic route(input logic [15:0] dest, input logic [4:0] exp);
        int n;
        n = 0;
        routeDest <= dest;
        routeValid <= 1'b1;
        @(posedge mclk);
        routeValid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (routeDone !== 1'b1 && n < 10);
        chk("route result", 32'(exp), 32'({routeLocal, routeDir}));
    endtask

    initial begin
        {mclk, psel, penable, pwrite, coreZeroDebug, coreOneDebug, routeValid} = '0;
        {paddr, pwdata, routeDest, extStat, procStat, rxFull, badToken} = '0;
        rst = 1'b1;
        grantDelay = 8'h0c;
        nodeId = 16'h1234;
        for (int k = 0; k < 16; k++) dirTable[k] = 4'(k) ^ 4'h9;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(IDX_CFG + 10'h2, "cfg reset", 32'h0);
        rd(IDX_EXT + 10'h7, "ext reset", 32'h0);
        rd(IDX_RSVD_A, "rsvd reset", 32'h0);
        rd(IDX_STAT + 10'h5, "static reset", 32'h0);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            extStat[k] <= {2'(k), 8'(8'h10 + k), 1'(k), 1'(k >> 1), 1'(k != 0)};
            procStat[k] <= {2'(3 - k), 8'(8'h20 + k), 1'(k), 1'(k >> 1), 1'(k != 0)};
            w = 32'hfc00_f0c0 | {20'h0, 4'(k + 5), 2'h0, 2'(k), 4'h0};
            apb(1'b1, IDX_EXT + 10'(k), w);
            apb(1'b1, IDX_PROC + 10'(k), w);
            rd(IDX_EXT + 10'(k), "ext status", {6'h0, 2'(k), (k != 0) ? 8'(8'h10 + k) : 8'h00,
                4'h0, 4'(k + 5), 2'h0, 2'(k), 1'b0, 1'(k), 1'(k >> 1), 1'(k != 0)});
            rd(IDX_PROC + 10'(k), "proc status", {6'h0, 2'(3 - k), (k != 0) ? 8'(8'h20 + k) : 8'h00,
                8'h00, 2'h0, 2'(k), 1'b0, 1'(k), 1'(k >> 1), 1'(k != 0)});
            chk("ext dir net", {26'h0, 4'(k + 5), 2'(k)}, {26'h0, linkCfg[k].direction, linkCfg[k].network});
            chk("proc net", 32'(k), 32'(procNetwork[k]));
        end
        $display("test link status done");
        cfgW = {2'h3, 8'h00, 11'h155, 11'h2aa};
        apb(1'b1, IDX_CFG + 10'h2, cfgW);
        chk("cfg fields", 32'({2'h3, 4'h7, 2'h2, 11'h155, 11'h2aa}), 32'(linkCfg[2]));
        poll_credit();
        apb(1'b1, IDX_CFG + 10'h2, cfgW | 32'h0100_0000);
        rd(IDX_CFG + 10'h2, "credit dropped", cfgW | 32'h0400_0000);
        poll_credit();
        grantDelay <= 8'h01;
        apb(1'b1, IDX_CFG + 10'h2, cfgW | 32'h0100_0000);
        poll_credit();
        rxFull[2] <= 1'b1;
        apb(1'b0, IDX_CFG + 10'h2, 32'h0);
        chk("issued while full", 32'h0, 32'(rdq[CF_ISSUED_BIT]));
        chk("grant while full", 32'h0, 32'(creditGrantOk[2]));
        rxFull[2] <= 1'b0;
        badToken[2] <= 1'b1;
        @(posedge mclk);
        badToken[2] <= 1'b0;
        // Issued credit returns three edges after the buffer drains.
        repeat (2) @(posedge mclk);
        rd(IDX_CFG + 10'h2, "rx error", cfgW | 32'h0e00_0000);
        apb(1'b1, IDX_CFG + 10'h2, cfgW | 32'h0080_0000);
        rd(IDX_CFG + 10'h2, "rx reset", cfgW | 32'h0600_0000);
        $display("test link config done");
        for (int k = 0; k < 8; k++) apb(1'b1, IDX_STAT + 10'(k), 32'hffff_ffe0 | 32'(k + 3));
        for (int k = 0; k < 8; k++) begin
            rd(IDX_STAT + 10'(k), "static reg", 32'h8000_0000 | 32'(k + 3));
            chk("static map", 32'(k + 35), {26'h0, staticEnable[STAT_LINK[k]],
                staticChanEnd[STAT_LINK[k]]});
        end
        $display("test static forwarding done");
        coreZeroDebug <= 1'b1;
        @(posedge mclk);
        coreZeroDebug <= 1'b0;
        rd(IDX_DBG, "debug zero", 32'h1);
        coreOneDebug <= 1'b1;
        @(posedge mclk);
        coreOneDebug <= 1'b0;
        rd(IDX_DBG, "debug one", 32'h2);
        apb(1'b1, IDX_RSVD_B, 32'hffff_ffff);
        rd(IDX_RSVD_B, "rsvd bits", 32'h3);
        rd(10'h028, "unmapped", 32'h0);
        chk("unmapped err", 32'h1, 32'(errq));
        route(16'h1214, 5'h0c);
        route(16'h9235, 5'h06);
        route(16'h1234, 5'h19);
        $display("test registers and routing done");
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
endmodule
